// >>> logic/prsd_defs.svh
// Purpose: Offsets, field positions, reset values and timing in nanoseconds.
// Assumes: Byte-wide registers on a 10-bit address port.
// Notes: Definitions only.
`ifndef PRSD_DEFS_SVH
`define PRSD_DEFS_SVH
// Register offsets.
`define PRSD_A_POWER 10'h010
`define PRSD_A_RDIV_LO 10'h011
`define PRSD_A_RDIV_HI 10'h012
`define PRSD_A_SWAL 10'h013
`define PRSD_A_MAIN_LO 10'h014
`define PRSD_A_MAIN_HI 10'h015
`define PRSD_A_PRESC 10'h016
`define PRSD_A_RESETS 10'h018
`define PRSD_A_SYNC 10'h019
`define PRSD_A_MONSEL 10'h01B
`define PRSD_A_REFCTL 10'h01C
`define PRSD_A_AUTOCTL 10'h01D
`define PRSD_A_STATUS 10'h01F
`define PRSD_A_UPDATE 10'h232
`define PRSD_UPDATE_GO 8'h01
// Field positions.
`define PRSD_B_DIFF_MODE 0
`define PRSD_B_PRI_ON 1
`define PRSD_B_SEC_ON 2
`define PRSD_B_PIN_SEL 4
`define PRSD_B_AUTO 5
`define PRSD_B_MAN_SEC 6
`define PRSD_B_DEGL_OFF 7
`define PRSD_B_USE_STATUS 0
`define PRSD_B_PREFER_SEC 1
`define PRSD_B_STAT_SEC 2
`define PRSD_B_RST_R 0
`define PRSD_B_RST_AB 1
`define PRSD_B_RST_ALL 2
`define PRSD_B_SYNC_EN 7
// Monitor pin selection codes.
`define PRSD_MON_PRI_BAD 8'hF7
`define PRSD_MON_SEC_BAD 8'hF6
// Reset values.
`define PRSD_RST_BYTE 8'h00
`define PRSD_RST_POWER 8'h01
// Timing.
`define PRSD_CLK_PERIOD_NS 5
`define PRSD_REF_LOSS_NS 320
`endif

// >>> logic/prsd_pkg.sv
// Purpose: Types shared by the reference select and divider block.
// Assumes: Constants live in prsd_defs.svh.
// Notes: One-hot switch states.
`default_nettype none
package prsd_pkg;
    // Reference switch states, one-hot.
    typedef enum logic [3:0] {
        PRSD_SW_PRI = 4'b0001,
        PRSD_SW_TO_SEC = 4'b0010,
        PRSD_SW_SEC = 4'b0100,
        PRSD_SW_TO_PRI = 4'b1000
    } prsd_sw_t;
    // Register index type for the configuration bank.
    typedef logic [3:0] prsd_idx_t;
endpackage : prsd_pkg
`default_nettype wire

// >>> logic/prsd_top.sv
// Purpose: Reference select, power-down, switchover, R and N dividers.
// Assumes: All pins are synchronous to clk; clk is 200 MHz.
// Notes: Configuration writes land in a shadow bank; the update register
// copies them into the active bank that steers the logic.
//
// The plain strobed port and the address map were chosen for this implementation.
`include "prsd_defs.svh"
`default_nettype none
module prsd_top
    import prsd_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Reference and feedback pins.
    input wire logic primary_single_ended_input,
    input wire logic secondary_single_ended_input,
    input wire logic fb_clk_in,
    input wire logic ref_sel_pin,
    input wire logic sync_n,
    // Phase detector inputs.
    output logic pfd_ref_q,
    output logic pfd_fb_q,
    // Buffer power and status pins.
    output logic diff_buf_on_q,
    output logic pri_buf_on_q,
    output logic sec_buf_on_q,
    output logic source_monitor_pin,
    output logic status_pin,
    output logic sel_secondary_q
);
    // Cycles without an edge on an input before that input counts as lost.
    localparam int LOSS_CYC = `PRSD_REF_LOSS_NS / `PRSD_CLK_PERIOD_NS;

    // Shadow bank written by software, active bank used by the logic.
    logic [7:0] shadow_q [14];
    logic [7:0] active_q [14];
    // Counter reset bits act at once and stay until cleared.
    logic [7:0] resets_q;
    // Registered read data.
    logic [7:0] rdata_q;

    // Address decode.
    wire in_bank = (reg_addr >= `PRSD_A_POWER) && (reg_addr <= `PRSD_A_AUTOCTL);
    wire prsd_idx_t idx = prsd_idx_t'(reg_addr - `PRSD_A_POWER);
    wire wr_bank = reg_wr && in_bank;
    wire wr_resets = reg_wr && (reg_addr == `PRSD_A_RESETS);
    wire update_go = reg_wr && (reg_addr == `PRSD_A_UPDATE) && (reg_wdata == `PRSD_UPDATE_GO);

    // Active fields.
    wire [7:0] power_a = active_q[0];
    wire [13:0] rdiv_a = {active_q[2][5:0], active_q[1]};
    wire [5:0] swal_a = active_q[3][5:0];
    wire [12:0] main_a = {active_q[5][4:0], active_q[4]};
    wire [2:0] presc_a = active_q[6][2:0];
    wire [7:0] sync_a = active_q[9];
    wire [7:0] monsel_a = active_q[11];
    wire [7:0] refctl_a = active_q[12];
    wire [7:0] autoctl_a = active_q[13];

    // Loop power and buffer enables.
    wire loop_on = (power_a[1:0] == 2'b00);
    wire diff_mode = refctl_a[`PRSD_B_DIFF_MODE];
    // Differential buffer runs only with the loop on and its mode chosen.
    wire diff_on = loop_on && diff_mode && refctl_a[`PRSD_B_PRI_ON];
    // Single-ended buffers: own bit, loop power, and off in differential mode.
    wire pri_on = loop_on && !diff_mode && refctl_a[`PRSD_B_PRI_ON];
    wire sec_on = loop_on && !diff_mode && refctl_a[`PRSD_B_SEC_ON];

    // Gated pin levels; a disabled buffer reads as a quiet low.
    wire pri_lvl = pri_on && primary_single_ended_input;
    wire sec_lvl = sec_on && secondary_single_ended_input;
    // In differential mode the pair is read as one comparator level.
    wire diff_lvl = diff_on && primary_single_ended_input && !secondary_single_ended_input;

    // Previous levels for edge detection.
    logic pri_prev_q;
    logic sec_prev_q;
    logic mux_prev_q;
    logic fb_prev_q;
    // Loss monitors count cycles since the last rising edge.
    logic [6:0] pri_gap_q;
    logic [6:0] sec_gap_q;

    wire pri_edge = pri_lvl && !pri_prev_q;
    wire sec_edge = sec_lvl && !sec_prev_q;
    wire pri_bad = !pri_on || (pri_gap_q >= 7'(LOSS_CYC));
    wire sec_bad = !sec_on || (sec_gap_q >= 7'(LOSS_CYC));

    // Loss monitors saturate at the loss threshold.
    always_ff @(posedge clk) begin
        if (rst) begin
            pri_gap_q <= 7'h00;
            sec_gap_q <= 7'h00;
        end else begin
            pri_gap_q <= pri_edge ? 7'h00 : (pri_bad ? pri_gap_q : pri_gap_q + 7'h01);
            sec_gap_q <= sec_edge ? 7'h00 : (sec_bad ? sec_gap_q : sec_gap_q + 7'h01);
        end
    end

    // Monitor pin shows a bad primary or secondary per its select code.
    wire mon_d = (monsel_a == `PRSD_MON_PRI_BAD) ? pri_bad :
                 (monsel_a == `PRSD_MON_SEC_BAD) ? sec_bad : 1'b0;
    // Status pin shows either loss flag, chosen by a control bit.
    wire stat_d = autoctl_a[`PRSD_B_STAT_SEC] ? sec_bad : pri_bad;

    // Selection request. Automatic mode follows the pin level and returns to
    // the preferred input as soon as it recovers; there is no latching.
    wire prefer_sec = autoctl_a[`PRSD_B_PREFER_SEC];
    wire auto_cmd = autoctl_a[`PRSD_B_USE_STATUS] ? stat_d : mon_d;
    wire auto_sec = prefer_sec ? !auto_cmd : auto_cmd;
    wire man_sec = refctl_a[`PRSD_B_PIN_SEL] ? ref_sel_pin : refctl_a[`PRSD_B_MAN_SEC];
    wire want_sec = refctl_a[`PRSD_B_AUTO] ? auto_sec : man_sec;
    wire degl_on = !refctl_a[`PRSD_B_DEGL_OFF];

    // Switch state machine.
    prsd_sw_t sw_q;
    prsd_sw_t sw_d;

    // With deglitching on, a switch completes only while the new input is
    // low, so the mux never makes a rising edge out of step with it. A target
    // held high leaves the switch pending for good.
    always_comb begin
        sw_d = sw_q;
        unique case (sw_q)
            PRSD_SW_PRI: begin
                if (want_sec) begin
                    sw_d = degl_on ? PRSD_SW_TO_SEC : PRSD_SW_SEC;
                end
            end
            PRSD_SW_TO_SEC: begin
                if (!want_sec) begin
                    sw_d = PRSD_SW_PRI;
                end else if (!degl_on || !sec_lvl) begin
                    sw_d = PRSD_SW_SEC;
                end
            end
            PRSD_SW_SEC: begin
                if (!want_sec) begin
                    sw_d = degl_on ? PRSD_SW_TO_PRI : PRSD_SW_PRI;
                end
            end
            PRSD_SW_TO_PRI: begin
                if (want_sec) begin
                    sw_d = PRSD_SW_SEC;
                end else if (!degl_on || !pri_lvl) begin
                    sw_d = PRSD_SW_PRI;
                end
            end
        endcase
    end

    // Outside differential mode, the loop uses the secondary while in or leaving the secondary state.
    wire use_sec = !diff_mode && ((sw_q == PRSD_SW_SEC) || (sw_q == PRSD_SW_TO_PRI));
    wire mux_lvl = diff_mode ? diff_lvl : (use_sec ? sec_lvl : pri_lvl);
    wire ref_edge = mux_lvl && !mux_prev_q;
    wire fb_edge = fb_clk_in && !fb_prev_q;

    // Divider resets: own bits, shared bit, and the sync pin when enabled.
    wire sync_rst = sync_a[`PRSD_B_SYNC_EN] && !sync_n;
    wire r_rst = resets_q[`PRSD_B_RST_R] || resets_q[`PRSD_B_RST_ALL] || sync_rst;
    wire ab_rst = resets_q[`PRSD_B_RST_AB] || resets_q[`PRSD_B_RST_ALL] || sync_rst;

    // R divider limit: zero and one both divide by one.
    wire [13:0] r_lim = (rdiv_a < 14'h0002) ? 14'h0001 : rdiv_a;

    // Prescaler modulus: codes 0..4 dual-modulus 2..32, 5..7 fixed 1..3.
    wire fixed_mode = (presc_a >= 3'h5);
    wire [5:0] p_val = fixed_mode ? {3'h0, presc_a - 3'h4} : (6'h02 << presc_a);
    // Swallow count reads as zero in a fixed mode.
    wire [5:0] a_eff = fixed_mode ? 6'h00 : swal_a;
    // Total ratio N = P * B + A, up to 262,175.
    wire [18:0] n_raw = 19'(p_val) * 19'(main_a) + 19'(a_eff);
    wire [18:0] n_lim = (n_raw == 19'h00000) ? 19'h00001 : n_raw;

    // Divider counters.
    logic [13:0] r_cnt_q;
    logic [18:0] n_cnt_q;
    wire r_wrap = ref_edge && (r_cnt_q >= r_lim - 14'h0001);
    wire n_wrap = fb_edge && (n_cnt_q >= n_lim - 19'h00001);

    // Register writes, update transfer and reset bits.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 14; i++) begin
                shadow_q[i] <= (i == 0) ? `PRSD_RST_POWER : `PRSD_RST_BYTE;
                active_q[i] <= (i == 0) ? `PRSD_RST_POWER : `PRSD_RST_BYTE;
            end
            resets_q <= `PRSD_RST_BYTE;
        end else begin
            if (wr_bank) begin
                shadow_q[idx] <= reg_wdata;
            end
            // New settings only reach the logic on an update.
            if (update_go) begin
                active_q <= shadow_q;
            end
            // Reset bits are not self-clearing.
            if (wr_resets) begin
                resets_q <= reg_wdata;
            end
        end
    end

    // Read data stands in the cycle after the read strobe.
    wire [7:0] status_rd = {4'h0, (sw_q == PRSD_SW_TO_SEC) || (sw_q == PRSD_SW_TO_PRI),
                            use_sec, !sec_bad, !pri_bad};
    wire [7:0] rd_d = in_bank ? shadow_q[idx] :
                      (reg_addr == `PRSD_A_RESETS) ? resets_q :
                      (reg_addr == `PRSD_A_STATUS) ? status_rd : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_d : 8'h00;
        end
    end

    // Edge history and switch state.
    always_ff @(posedge clk) begin
        if (rst) begin
            pri_prev_q <= 1'b0;
            sec_prev_q <= 1'b0;
            mux_prev_q <= 1'b0;
            fb_prev_q <= 1'b0;
            sw_q <= PRSD_SW_PRI;
        end else begin
            pri_prev_q <= pri_lvl;
            sec_prev_q <= sec_lvl;
            mux_prev_q <= mux_lvl;
            fb_prev_q <= fb_clk_in;
            sw_q <= sw_d;
        end
    end

    // Reference divider: one pulse per r_lim selected edges.
    always_ff @(posedge clk) begin
        if (rst || r_rst) begin
            r_cnt_q <= 14'h0000;
            pfd_ref_q <= 1'b0;
        end else begin
            if (ref_edge) begin
                r_cnt_q <= r_wrap ? 14'h0000 : r_cnt_q + 14'h0001;
            end
            pfd_ref_q <= r_wrap;
        end
    end

    // Feedback divider: one pulse per n_lim feedback edges.
    always_ff @(posedge clk) begin
        if (rst || ab_rst) begin
            n_cnt_q <= 19'h00000;
            pfd_fb_q <= 1'b0;
        end else begin
            if (fb_edge) begin
                n_cnt_q <= n_wrap ? 19'h00000 : n_cnt_q + 19'h00001;
            end
            pfd_fb_q <= n_wrap;
        end
    end

    // Registered pin and enable outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            diff_buf_on_q <= 1'b0;
            pri_buf_on_q <= 1'b0;
            sec_buf_on_q <= 1'b0;
            source_monitor_pin <= 1'b0;
            status_pin <= 1'b0;
            sel_secondary_q <= 1'b0;
        end else begin
            diff_buf_on_q <= diff_on;
            pri_buf_on_q <= pri_on;
            sec_buf_on_q <= sec_on;
            source_monitor_pin <= mon_d;
            status_pin <= stat_d;
            sel_secondary_q <= use_sec;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : prsd_top
`default_nettype wire

// >>> dv/prsd_checker.sv
// Purpose: Port-level assertions for the reference select and divider block.
// Assumes: Sees only prsd_top ports; bound from the bench top file.
// Notes: Mirrors the power and reference control banks from bus writes.
`include "prsd_defs.svh"
`default_nettype none
module prsd_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pulses and buffer levels.
    input wire logic pfd_ref_q,
    input wire logic pfd_fb_q,
    input wire logic diff_buf_on_q,
    input wire logic pri_buf_on_q,
    input wire logic sec_buf_on_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] sh_pwr_q, sh_ref_q, pwr_q, ref_q; // Shadow and active copies.
    logic r_hold_q, ab_hold_q; // Counter reset bits as last written.
    wire logic pd = pwr_q[1:0] != 2'b00; // Loop is powered down.
    // Writes fill the shadow; the update code copies it to the active bank.
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_pwr_q <= `PRSD_RST_POWER;
            pwr_q <= `PRSD_RST_POWER;
            sh_ref_q <= 8'h00;
            ref_q <= 8'h00;
            r_hold_q <= 1'b0;
            ab_hold_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `PRSD_A_POWER) sh_pwr_q <= reg_wdata;
            if (reg_addr == `PRSD_A_REFCTL) sh_ref_q <= reg_wdata;
            if (reg_addr == `PRSD_A_RESETS) begin
                r_hold_q <= reg_wdata[0] | reg_wdata[2];
                ab_hold_q <= reg_wdata[1] | reg_wdata[2];
            end
            if (reg_addr == `PRSD_A_UPDATE && reg_wdata == `PRSD_UPDATE_GO) begin
                pwr_q <= sh_pwr_q;
                ref_q <= sh_ref_q;
            end
        end
    end
    // Read data appears only in the slot after a read strobe.
    rdata_slot_a: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data outside its slot");
    unmapped_read_a: assert property (reg_rd && reg_addr == 10'h3FF |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    ref_pulse_a: assert property (pfd_ref_q |=> !pfd_ref_q)
        else $error("reference pulse too long");
    fb_pulse_a: assert property (pfd_fb_q |=> !pfd_fb_q)
        else $error("feedback pulse too long");
    loop_down_a: assert property (pd && $past(pd) && $past(pd, 2)
        |-> !diff_buf_on_q && !pri_buf_on_q && !sec_buf_on_q) else $error("buffer on in power down");
    pri_enable_a: assert property (!ref_q[1] && !$past(ref_q[1]) && !$past(ref_q[1], 2)
        |-> !pri_buf_on_q && !diff_buf_on_q) else $error("primary buffer on unasked");
    sec_enable_a: assert property (!ref_q[2] && !$past(ref_q[2]) && !$past(ref_q[2], 2)
        |-> !sec_buf_on_q) else $error("secondary buffer on unasked");
    diff_mode_a: assert property (!ref_q[0] && !$past(ref_q[0]) && !$past(ref_q[0], 2)
        |-> !diff_buf_on_q) else $error("pair buffer on outside pair mode");
    se_off_diff_a: assert property (ref_q[0] && $past(ref_q[0]) && $past(ref_q[0], 2)
        |-> !pri_buf_on_q && !sec_buf_on_q) else $error("single buffer on in pair mode");
    r_hold_a: assert property (r_hold_q && $past(r_hold_q) && $past(r_hold_q, 3)
        |-> !pfd_ref_q) else $error("reference pulse during reset");
    ab_hold_a: assert property (ab_hold_q && $past(ab_hold_q) && $past(ab_hold_q, 3)
        |-> !pfd_fb_q) else $error("feedback pulse during reset");
endmodule : prsd_checker
`default_nettype wire

// >>> dv/prsd_ref_src.sv
// Purpose: Models the reference sources and the oscillator feedback.
// Assumes: Levels change on clk; index 0 primary, 1 secondary, 2 feedback.
// Notes: Half period is set per source; a stopped source sits low.
`default_nettype none
module prsd_ref_src (
    // Clock.
    input wire logic clk,
    // Per source run enable and half period in cycles.
    input wire logic [2:0] run,
    input wire logic [2:0][7:0] half,
    // Source levels.
    output wire logic [2:0] lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0][7:0] cnt_q = '0; // Cycles into the current half period.
    logic [2:0] lvl_q = 3'b000; // Present level of each source.
    assign lvl = lvl_q;
    // Sources run from time zero, so setup and any retune see a live reference.
    // Running sources keep toggling, so a switch target is live.
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (!run[i]) begin
                cnt_q[i] <= 8'h00;
                lvl_q[i] <= 1'b0;
            end else if (cnt_q[i] + 8'h01 >= half[i]) begin
                // Half period of at least one cycle stays under 200 MHz.
                cnt_q[i] <= 8'h00;
                lvl_q[i] <= ~lvl_q[i];
            end else begin
                cnt_q[i] <= cnt_q[i] + 8'h01;
            end
        end
    end
endmodule : prsd_ref_src
`default_nettype wire

// >>> dv/prsd_top_bench.sv
// Purpose: Self-checking bench for the reference select and divider block.
// Assumes: Source model drives the pins; seed 45 fixes the random values.
// Notes: Divider ratios are checked as spacing between output pulses.
`include "prsd_defs.svh"
`default_nettype none
module prsd_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sel_pin = 1'b0, sync_n = 1'b1;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic pfd_ref_q, pfd_fb_q, diff_on, pri_on, sec_on, mon, stat, sel_sec;
    logic [2:0] run = 3'b111, lvl;
    logic [2:0][7:0] half = {8'h01, 8'h03, 8'h02}; // Feedback, secondary, primary.
    int n_fail = 0, n_tests = 0, cyc = 0, n, a, b, c;
    // Power, control, expected {pair, primary, secondary} buffer levels.
    logic [18:0] bt [8] = '{{8'h01, 8'h07, 3'b000}, {8'h00, 8'h00, 3'b000},
        {8'h00, 8'h06, 3'b011}, {8'h00, 8'h02, 3'b010}, {8'h00, 8'h03, 3'b100},
        {8'h00, 8'h07, 3'b100}, {8'h02, 8'h06, 3'b000}, {8'h00, 8'h04, 3'b001}};
    // Control, select pin, expected selection of the secondary.
    logic [9:0] ms [5] = '{{8'h06, 2'b00}, {8'h46, 2'b01}, {8'h16, 2'b11},
        {8'h16, 2'b00}, {8'hC6, 2'b01}};
    logic [7:0] rc [4] = '{8'h01, 8'h02, 8'h04, 8'h00}; // Counter reset codes.
    always #2.5 clk = ~clk;
    prsd_ref_src prsd_ref_src_inst (.clk(clk), .run(run), .half(half), .lvl(lvl));
    prsd_top prsd_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .primary_single_ended_input(lvl[0]), .secondary_single_ended_input(lvl[1]),
        .fb_clk_in(lvl[2]), .ref_sel_pin(sel_pin), .sync_n(sync_n), .pfd_ref_q(pfd_ref_q),
        .pfd_fb_q(pfd_fb_q), .diff_buf_on_q(diff_on), .pri_buf_on_q(pri_on),
        .sec_buf_on_q(sec_on), .source_monitor_pin(mon), .status_pin(stat),
        .sel_secondary_q(sel_sec));
    // Expected feedback ratio: dual-modulus P times B plus A, fixed ignores A.
    function automatic int nexp(int c, int a, int b);
        int r;
        r = (c < 5) ? (2 << c) * b + a : (c - 4) * b;
        return (r == 0) ? 1 : r;
    endfunction : nexp
    // Compares a seen value with the expected one and counts both.
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask : chk
    // One-cycle register write.
    task automatic wr(input logic [9:0] ad, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Register read; the data stand in the following cycle only.
    task automatic rd(input logic [9:0] ad, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // New settings only act after the update code.
    task automatic upd();
        wr(`PRSD_A_UPDATE, `PRSD_UPDATE_GO);
    endtask : upd
    // Cycles between the second and third pulse of one divider.
    task automatic gap(input bit fb, output int g);
        int k;
        k = 0;
        g = 0;
        for (int t = 0; t < 9000 && k < 3; t++) begin
            @(negedge clk);
            g++;
            if ((fb ? pfd_fb_q : pfd_ref_q) === 1'b1) begin
                k++;
                if (k < 3) g = 0;
            end
        end
    endtask : gap
    // Counts pulses of both dividers over 64 cycles.
    task automatic cnt(output int nr, output int nf);
        nr = 0;
        nf = 0;
        repeat (64) begin
            @(negedge clk);
            nr += (pfd_ref_q === 1'b1);
            nf += (pfd_fb_q === 1'b1);
        end
    endtask : cnt
    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        void'($urandom(45));
        half[1] <= 8'(2 + $urandom % 3);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`PRSD_A_POWER, `PRSD_RST_POWER);
        rd(`PRSD_A_REFCTL, 8'h00);
        rd(10'h3FF, 8'h00);
        chk({diff_on, pri_on, sec_on}, 3'b000);
        foreach (bt[i]) begin
            wr(`PRSD_A_POWER, bt[i][18:11]);
            wr(`PRSD_A_REFCTL, bt[i][10:3]);
            rd(`PRSD_A_REFCTL, bt[i][10:3]);
            upd();
            repeat (4) @(posedge clk);
            #1 chk({diff_on, pri_on, sec_on}, bt[i][2:0]);
        end
        wr(`PRSD_A_REFCTL, 8'h02);
        for (int i = 0; i < 4; i++) begin
            n = (i == 3) ? 257 : (i < 2) ? i : 2 + $urandom % 14;
            wr(`PRSD_A_RDIV_LO, 8'(n));
            wr(`PRSD_A_RDIV_HI, 8'(n >> 8));
            upd();
            gap(1'b0, a);
            chk(16'(a), 16'(((n < 2) ? 1 : n) * 4));
        end
        for (int i = 0; i < 9; i++) begin
            c = (i == 8) ? 5 : i;
            b = (i == 8) ? 1 : 3 + $urandom % 4;
            a = (i == 8) ? 7 : $urandom % b;
            wr(`PRSD_A_SWAL, 8'(a));
            wr(`PRSD_A_MAIN_LO, 8'(b));
            wr(`PRSD_A_PRESC, 8'(c));
            upd();
            gap(1'b1, n);
            chk(16'(n), 16'(nexp(c, a, b) * 2));
        end
        wr(`PRSD_A_RDIV_LO, 8'h02);
        wr(`PRSD_A_RDIV_HI, 8'h00);
        upd();
        for (int i = 0; i < 4; i++) begin
            wr(`PRSD_A_RESETS, rc[i]);
            if (i == 3) begin
                wr(`PRSD_A_SYNC, 8'h80);
                upd();
                sync_n <= 1'b0;
            end
            repeat (4) @(posedge clk);
            cnt(n, a);
            chk(n == 0, i != 1);
            chk(a == 0, i != 0);
            wr(`PRSD_A_RESETS, 8'h00);
            sync_n <= 1'b1;
        end
        wr(`PRSD_A_MONSEL, `PRSD_MON_PRI_BAD);
        wr(`PRSD_A_REFCTL, 8'h26);
        upd();
        for (int i = 0; i < 3; i++) begin
            run[0] <= (i != 1);
            repeat (150) @(posedge clk);
            #1 chk({mon, sel_sec}, {2{i == 1}});
            rd(`PRSD_A_STATUS, (i == 1) ? 8'h06 : 8'h03);
        end
        wr(`PRSD_A_AUTOCTL, 8'h07);
        wr(`PRSD_A_MONSEL, `PRSD_MON_SEC_BAD);
        upd();
        for (int i = 0; i < 3; i++) begin
            run[1] <= (i != 1);
            repeat (150) @(posedge clk);
            #1 chk({mon, stat, sel_sec}, (i == 1) ? 3'b110 : 3'b001);
        end
        wr(`PRSD_A_AUTOCTL, 8'h00);
        foreach (ms[i]) begin
            sel_pin <= ms[i][1];
            wr(`PRSD_A_REFCTL, ms[i][9:2]);
            upd();
            repeat (20) @(posedge clk);
            #1 chk(sel_sec, ms[i][0]);
        end
        test_done();
    end
endmodule : prsd_top_bench
bind prsd_top prsd_checker prsd_checker_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pfd_ref_q(pfd_ref_q), .pfd_fb_q(pfd_fb_q), .diff_buf_on_q(diff_buf_on_q),
    .pri_buf_on_q(pri_buf_on_q), .sec_buf_on_q(sec_buf_on_q));
`default_nettype wire
